/* core/nbx_pkg.sv */
// Package for the nibble bus I/O expander and its host end.
// Assumes a single 50 MHz clock shared by both ends.
package nbx_pkg;
    // Width of the nibble bus and of each expansion port.
    localparam int NBX_W = 4;
    // Number of expansion ports.
    localparam int NBX_PORTS = 4;
    // Port numbers as the host counts them.
    localparam int NBX_FIRST_PORT = 4;
    // Field positions within the first nibble.
    localparam int NBX_SEL_LSB = 0;
    localparam int NBX_OP_LSB = 2;
    // Latched port value after reset.
    localparam logic [3:0] NBX_PORT_RST = 4'h0;
    // Clock period and least strobe low time.
    localparam int NBX_CLK_NS = 20;
    localparam int NBX_STB_LOW_NS = 900;
    localparam int NBX_STB_LOW_CYC =
        (NBX_STB_LOW_NS + NBX_CLK_NS - 1) / NBX_CLK_NS;

    // Opcodes carried in the two high lines of the first nibble.
    typedef enum logic [1:0] {
        NBX_OP_READ  = 2'h0,
        NBX_OP_OVER  = 2'h1,
        NBX_OP_OR    = 2'h2,
        NBX_OP_AND   = 2'h3
    } nbx_op_e;

    // Forms the first nibble from opcode and port select.
    function automatic logic [3:0] nbx_first(input nbx_op_e op,
                                             input logic [1:0] sel);
        nbx_first = {op, sel};
    endfunction : nbx_first
endpackage : nbx_pkg

/* core/nbx_if.sv */
// Interface joining the host end and the expander end of the nibble bus.
// Resolves the shared bus itself from both enables; the expander end's drive wins.
`timescale 1ns/100ps
interface nbx_if;
    logic       transfer_strobe;
    logic       cs_n;
    logic [3:0] host_bus_o;
    logic       host_bus_oe_n;
    logic [3:0] dev_bus_o;
    logic       dev_bus_oe_n;
    logic [3:0] host_nibble_bus;

    // Resolved bus level; a floating bus reads as all ones.
    assign host_nibble_bus = !dev_bus_oe_n ? dev_bus_o :
                             !host_bus_oe_n ? host_bus_o : 4'hF;

    modport dev (input transfer_strobe, input cs_n, input host_nibble_bus,
                 output dev_bus_o, output dev_bus_oe_n);
    modport host (output transfer_strobe, output cs_n,
                  input host_nibble_bus,
                  output host_bus_o, output host_bus_oe_n);
endinterface : nbx_if

/* core/nbx_expander.sv */
// Expander end: four 4-bit static ports driven from the nibble bus.
// Assumes strobe, select and bus arrive from another part of the system,
// so each passes a two-stage synchroniser before use.
//
// How it works
// - four 4-bit ports, numbered four to seven.
// - each transfer is opcode nibble then data.
// - low two lines select the port.
// - high two lines give the opcode.
// - reset floats ports and bus.
// - power-on mode ends at first strobe fall.
// - strobe fall latches opcode and port.
// - read floats the port, enables input.
// - read drives port value before strobe rise.
// - strobe rise ends read, floats bus.
// - write data sampled at strobe rise.
// - overwrite replaces the latched value.
// - OR-write ORs data into latch.
// - AND-write ANDs data into latch.
// - written port keeps driving its latch.
// - host drops first read after write; nbx_host returns every read, only the bench discards one.
// - deselected chip changes nothing.
// - host decodes one select per expander.
// - host holds strobe low 900 ns minimum.
`timescale 1ns/100ps
module nbx_expander
    import nbx_pkg::*;
#(
    parameter int PORTS = nbx_pkg::NBX_PORTS
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    nbx_if.dev                         bus,
    input  wire logic [PORTS*4-1:0]    exp_port_i,
    output logic      [PORTS*4-1:0]    exp_port_o,
    output logic      [PORTS-1:0]      exp_port_oe_n
);
    import nbx_pkg::*;

    // Elaboration check: the two-line port decode serves four ports only.
    if (PORTS != NBX_PORTS) begin : g_bad_ports
        $error("nbx_expander serves exactly four ports");
    end

    typedef enum logic [2:0] {
        NBX_ST_PWRON = 3'b001,
        NBX_ST_IDLE  = 3'b010,
        NBX_ST_CMD   = 3'b100
    } nbx_dst_e;

    logic [1:0]        stb_s_q;
    logic [1:0]        cs_s_q;
    logic [3:0]        bus_s1_q;
    logic [3:0]        bus_s2_q;
    logic              stb_d1_q;
    logic [15:0]       pin_s1_q;
    logic [15:0]       pin_s2_q;
    nbx_dst_e          st_q;
    nbx_op_e           op_q;
    logic [1:0]        sel_q;
    logic [3:0]        lat_q [PORTS];
    logic [PORTS-1:0]  drv_q;
    logic [3:0]        rd_q;
    logic              rd_oe_q;
    logic              fall;
    logic              rise;
    logic              sel_n;

    // Two-flop synchronisers on every pin input.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stb_s_q  <= 2'h0;
            cs_s_q   <= 2'h3;
            bus_s1_q <= 4'h0;
            bus_s2_q <= 4'h0;
            pin_s1_q <= 16'h0000;
            pin_s2_q <= 16'h0000;
        end else begin
            stb_s_q  <= {stb_s_q[0], bus.transfer_strobe};
            cs_s_q   <= {cs_s_q[0], bus.cs_n};
            bus_s1_q <= bus.host_nibble_bus;
            bus_s2_q <= bus_s1_q;
            pin_s1_q <= exp_port_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Edge detect on the synchronised strobe. The delayed copy resets low,
    // like the synchroniser, so a strobe held low through reset still
    // needs a real high level and then a fall to leave power-on mode.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stb_d1_q <= 1'b0;
        end else begin
            stb_d1_q <= stb_s_q[1];
        end
    end

    assign fall  = stb_d1_q && !stb_s_q[1];
    assign rise  = !stb_d1_q && stb_s_q[1];
    assign sel_n = cs_s_q[1];

    // Sequence and command capture.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q  <= NBX_ST_PWRON;
            op_q  <= NBX_OP_READ;
            sel_q <= 2'h0;
        end else if (!sel_n) begin
            case (st_q)
                NBX_ST_PWRON, NBX_ST_IDLE: begin
                    if (fall) begin
                        st_q  <= NBX_ST_CMD;
                        op_q  <= nbx_op_e'(bus_s2_q[NBX_OP_LSB +: 2]);
                        sel_q <= bus_s2_q[NBX_SEL_LSB +: 2];
                    end
                end
                NBX_ST_CMD: begin
                    if (rise) begin
                        st_q <= NBX_ST_IDLE;
                    end
                end
                default: begin
                    st_q <= NBX_ST_PWRON;
                end
            endcase
        end
    end

    // Port latches and drivers, one set per port.
    for (genvar p = 0; p < PORTS; p++) begin : g_port
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                lat_q[p] <= NBX_PORT_RST;
                drv_q[p] <= 1'b0;
            end else if (!sel_n && st_q == NBX_ST_CMD && sel_q == 2'(p)) begin
                if (fall || op_q == NBX_OP_READ) begin
                    drv_q[p] <= (op_q == NBX_OP_READ) ? 1'b0 : drv_q[p];
                end
                if (rise && op_q != NBX_OP_READ) begin
                    case (op_q)
                        NBX_OP_OVER: lat_q[p] <= bus_s2_q;
                        NBX_OP_OR:   lat_q[p] <= lat_q[p] | bus_s2_q;
                        NBX_OP_AND:  lat_q[p] <= lat_q[p] & bus_s2_q;
                        default:     lat_q[p] <= lat_q[p];
                    endcase
                    drv_q[p] <= 1'b1;
                end
            end
        end
        assign exp_port_o[p*4 +: 4] = lat_q[p];
        assign exp_port_oe_n[p]     = !drv_q[p];
    end

    // Read data path back onto the nibble bus.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_q    <= 4'h0;
            rd_oe_q <= 1'b0;
        end else if (!sel_n) begin
            if (st_q == NBX_ST_CMD && op_q == NBX_OP_READ && !rise) begin
                rd_q    <= pin_s2_q[sel_q*4 +: 4];
                rd_oe_q <= 1'b1;
            end else begin
                rd_oe_q <= 1'b0;
            end
        end
    end

    assign bus.dev_bus_o    = rd_q;
    assign bus.dev_bus_oe_n = !rd_oe_q;
endmodule : nbx_expander

/* core/nbx_host.sv */
// Host end: turns one user request into a two-nibble strobed transfer.
// Assumes the expander samples through two-flop synchronisers.
`timescale 1ns/100ps
module nbx_host
    import nbx_pkg::*;
#(
    parameter int PHASE_CYC = nbx_pkg::NBX_STB_LOW_CYC
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    nbx_if.host              bus,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire nbx_op_e     req_op,
    input  wire logic [1:0]  req_sel,
    input  wire logic [3:0]  req_data,
    output logic             rsp_valid,
    output logic [3:0]       rsp_data
);
    import nbx_pkg::*;

    // Elaboration check: the phase must cover the least strobe low time
    // and fit the eight-bit phase counter.
    if (PHASE_CYC < NBX_STB_LOW_CYC || PHASE_CYC > 255) begin : g_bad_phase
        $error("nbx_host phase length out of range");
    end

    typedef enum logic [3:0] {
        NBX_H_IDLE = 4'b0001,
        NBX_H_CMD  = 4'b0010,
        NBX_H_LOW  = 4'b0100,
        NBX_H_GAP  = 4'b1000
    } nbx_hst_e;

    nbx_hst_e    st_q;
    logic [7:0]  cnt_q;
    nbx_op_e     op_q;
    logic [3:0]  nib_q;
    logic        stb_q;
    logic        cs_n_q;
    logic        oe_n_q;
    logic [3:0]  bus_s1_q;
    logic [3:0]  bus_s2_q;
    logic        rv_q;
    logic [3:0]  rd_q;

    assign req_ready = (st_q == NBX_H_IDLE);

    // Bus synchroniser for read data.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_s1_q <= 4'h0;
            bus_s2_q <= 4'h0;
        end else begin
            bus_s1_q <= bus.host_nibble_bus;
            bus_s2_q <= bus_s1_q;
        end
    end

    // Transfer sequencer; each phase lasts PHASE_CYC + 1 cycles.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q   <= NBX_H_IDLE;
            cnt_q  <= 8'h00;
            op_q   <= NBX_OP_READ;
            nib_q  <= 4'h0;
            stb_q  <= 1'b1;
            cs_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            rv_q   <= 1'b0;
            rd_q   <= 4'h0;
        end else begin
            rv_q <= 1'b0;
            case (st_q)
                NBX_H_IDLE: begin
                    if (req_valid) begin
                        st_q   <= NBX_H_CMD;
                        op_q   <= req_op;
                        nib_q  <= nbx_first(req_op, req_sel);
                        oe_n_q <= 1'b0;
                        cs_n_q <= 1'b0;
                        cnt_q  <= 8'(PHASE_CYC);
                        rd_q   <= req_data;
                    end
                end
                NBX_H_CMD: begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_q == 8'h00) begin
                        stb_q <= 1'b0;
                        st_q  <= NBX_H_LOW;
                        cnt_q <= 8'(PHASE_CYC);
                    end
                end
                NBX_H_LOW: begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_q == 8'(PHASE_CYC - 2)) begin
                        if (op_q == NBX_OP_READ) begin
                            oe_n_q <= 1'b1;
                        end else begin
                            nib_q <= rd_q;
                        end
                    end
                    if (cnt_q == 8'h00) begin
                        stb_q <= 1'b1;
                        st_q  <= NBX_H_GAP;
                        cnt_q <= 8'(PHASE_CYC);
                        if (op_q == NBX_OP_READ) begin
                            rv_q <= 1'b1;
                            rd_q <= bus_s2_q;
                        end
                    end
                end
                NBX_H_GAP: begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_q == 8'h00) begin
                        oe_n_q <= 1'b1;
                        cs_n_q <= 1'b1;
                        st_q   <= NBX_H_IDLE;
                    end
                end
                default: begin
                    st_q <= NBX_H_IDLE;
                end
            endcase
        end
    end

    assign bus.transfer_strobe = stb_q;
    assign bus.cs_n            = cs_n_q;
    assign bus.host_bus_o      = nib_q;
    assign bus.host_bus_oe_n   = oe_n_q;
    assign rsp_valid           = rv_q;
    assign rsp_data            = rd_q;
endmodule : nbx_host

/* tb/nbx_props.sv */
// Checker for the nibble bus between the host end and the expander end.
// Assumes instantiation beside the interface, on the one clock.
`timescale 1ns/100ps
module nbx_props #(
    parameter int PHASE_CYC = 45
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       transfer_strobe,
    input  wire logic       cs_n,
    input  wire logic [3:0] host_bus_o,
    input  wire logic       host_bus_oe_n,
    input  wire logic [3:0] dev_bus_o,
    input  wire logic       dev_bus_oe_n,
    input  wire logic [3:0] host_nibble_bus
);
    int unsigned low_cnt_q;
    logic        rd_q;
    logic        seen_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Counts the cycles that the strobe has been low.
    always_ff @(posedge clk) begin
        if (sys_rst || transfer_strobe) begin
            low_cnt_q <= 0;
        end else begin
            low_cnt_q <= low_cnt_q + 1;
        end
    end

    // Notes whether the current transfer is a read.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_q <= 1'b0;
        end else if ($fell(transfer_strobe)) begin
            rd_q <= (host_nibble_bus[3:2] == 2'h0);
        end
    end

    // Notes the first selected strobe fall, which ends power-on mode.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seen_q <= 1'b0;
        end else if ($fell(transfer_strobe) && !cs_n) begin
            seen_q <= 1'b1;
        end
    end

    reset_float_a: assert property ($past(sys_rst) |-> dev_bus_oe_n
        && host_bus_oe_n && transfer_strobe && cs_n) else $error("not idle");
    no_fight_a: assert property (!(!dev_bus_oe_n && !host_bus_oe_n))
        else $error("both ends drive the bus");
    low_time_a: assert property ($rose(transfer_strobe)
        |-> low_cnt_q >= PHASE_CYC) else $error("strobe low too short");
    rise_float_a: assert property ($rose(transfer_strobe)
        |-> ##[0:6] dev_bus_oe_n) else $error("bus not released");
    sel_drive_a: assert property (!dev_bus_oe_n |-> !cs_n)
        else $error("deselected expander drives");
    sel_low_a: assert property (!transfer_strobe |-> !cs_n)
        else $error("strobe low while deselected");
    cmd_fall_a: assert property ($fell(transfer_strobe)
        |-> !$past(host_bus_oe_n)) else $error("no command at fall");
    read_data_a: assert property ($rose(transfer_strobe) && rd_q
        |-> !$past(dev_bus_oe_n)) else $error("no read data at rise");
    write_data_a: assert property ($rose(transfer_strobe) && !rd_q
        |-> !$past(host_bus_oe_n)) else $error("no write data at rise");
    power_on_a: assert property (!seen_q |-> dev_bus_oe_n)
        else $error("drive before first strobe fall");
endmodule : nbx_props

/* tb/tb_top.sv */
// Bench joining host and expander ends through the interface.
// Assumes a 50 MHz clock and a synchronous active-high reset.
`timescale 1ns/100ps
module tb_top;
    import nbx_pkg::*;
    logic        clk;
    logic        sys_rst;
    logic        req_valid;
    logic        req_ready;
    nbx_op_e     req_op;
    logic [1:0]  req_sel;
    logic [3:0]  req_data;
    logic        rsp_valid;
    logic [3:0]  rsp_data;
    logic [15:0] exp_port_i;
    logic [15:0] exp_port_o;
    logic [3:0]  exp_port_oe_n;
    logic [15:0] ext_pins;
    logic [3:0]  got;
    int          fails;
    int          tests_run;
    int          cycles;

    nbx_if u_nbx_if ();
    nbx_host u_nbx_host (.clk(clk), .sys_rst(sys_rst), .bus(u_nbx_if.host),
        .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
        .req_sel(req_sel), .req_data(req_data), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data));
    nbx_expander u_nbx_expander (.clk(clk), .sys_rst(sys_rst),
        .bus(u_nbx_if.dev), .exp_port_i(exp_port_i),
        .exp_port_o(exp_port_o), .exp_port_oe_n(exp_port_oe_n));
    nbx_props u_nbx_props (.clk(clk), .sys_rst(sys_rst),
        .transfer_strobe(u_nbx_if.transfer_strobe), .cs_n(u_nbx_if.cs_n),
        .host_bus_o(u_nbx_if.host_bus_o),
        .host_bus_oe_n(u_nbx_if.host_bus_oe_n),
        .dev_bus_o(u_nbx_if.dev_bus_o), .dev_bus_oe_n(u_nbx_if.dev_bus_oe_n),
        .host_nibble_bus(u_nbx_if.host_nibble_bus));

    // Pin level: the expander's driver wins, else the outside drive.
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            exp_port_i[4*k +: 4] = exp_port_oe_n[k] ? ext_pins[4*k +: 4]
                                                    : exp_port_o[4*k +: 4];
        end
    end

    // Free-running clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Cuts a hung run short.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            $display("[ERR] %0t run timed out", $time);
            print_verdict();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("counts: tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    // Compares one nibble and reports a mismatch.
    task automatic check(input logic [3:0] g, input logic [3:0] e,
                         input string what);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, g, e);
        end
    endtask : check

    // Runs one host request and waits until the host is idle again.
    task automatic xfer(input nbx_op_e op, input logic [1:0] sel,
                        input logic [3:0] data);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 500) begin
            @(posedge clk);
            #1;
            n++;
        end
        req_op = op;
        req_sel = sel;
        req_data = data;
        req_valid = 1'b1;
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        n = 0;
        while (req_ready !== 1'b1 && n < 500) begin
            @(posedge clk);
            #1;
            if (rsp_valid === 1'b1) begin
                got = rsp_data;
            end
            n++;
        end
        if (n >= 500) begin
            fails++;
            $display("[ERR] %0t host did not return to idle", $time);
        end
    endtask : xfer

    // Main sequence of tests.
    initial begin
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req_op = NBX_OP_READ;
        req_sel = 2'h0;
        req_data = 4'h0;
        ext_pins = 16'hC3A5;
        got = 4'h0;
        cycles = 0;
        fails = 0;
        tests_run = 0;
        repeat (3) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        @(posedge clk);
        #1;
        check(exp_port_oe_n, 4'hF, "ports float");
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            xfer(NBX_OP_OVER, k[1:0], 4'h6 + k[3:0]);
            check(exp_port_o[4*k +: 4], 4'h6 + k[3:0], "write");
            check({3'h0, exp_port_oe_n[k]}, 4'h0, "drive");
        end
        $display("test overwrite done");
        xfer(NBX_OP_OR, 2'h2, 4'h3);
        check(exp_port_o[11:8], 4'hB, "or");
        xfer(NBX_OP_AND, 2'h2, 4'h6);
        check(exp_port_o[11:8], 4'h2, "and");
        xfer(NBX_OP_OVER, 2'h2, 4'hD);
        check(exp_port_o[11:8], 4'hD, "replace");
        check(exp_port_o[15:12], 4'h9, "other port");
        $display("test logic writes done");
        xfer(NBX_OP_READ, 2'h1, 4'h0);
        got = 4'h0;
        xfer(NBX_OP_READ, 2'h1, 4'h0);
        check(got, 4'hA, "read");
        check({3'h0, exp_port_oe_n[1]}, 4'h1, "read float");
        check(exp_port_o[11:8], 4'hD, "kept");
        xfer(NBX_OP_OVER, 2'h1, 4'h1);
        check(exp_port_o[7:4], 4'h1, "rewrite");
        check({3'h0, exp_port_oe_n[1]}, 4'h0, "redrive");
        $display("test read done");
        print_verdict();
    end
endmodule : tb_top
